// ---- rtl/plsc_port_regs.sv ----
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps

// Notes on behaviour
// - bw-mgmt enable set: interrupt whenever bw-mgmt status becomes set
// - autonomous-bw enable set: interrupt whenever autonomous status set
// - no bandwidth-notify capability: enables and statuses read zero
// - base 1.1 mode: bandwidth enables and statuses read-only zero
// - speed field bits 3:0 reports current speed, taken live from link_speed
// - width field bits 9:4 reports negotiated lane count
// - training error bit 10 set on failed training in 1.0a mode
// - bit 11 reads one while link training is in progress
// - slot clock bit 12 loads from port's strap; eeprom may override
// - bit 13 mirrors data link active, zero when not capable
// - bit 14 set when requested retrain completes without link down
// - bit 14 also set on reliability-driven autonomous speed/width change
// - bit 15 set on other autonomous changes; write one clears
// - downstream port sets bit 15 after eight flagged ordered sets
// - slot cap bits 0..4 flag button, power, sensor, indicators
// - slot cap bit 5 flags surprise removal
// - slot cap bits 0..5 read zero when slot not implemented
// - writing one to retrain bit starts recovery (on an upstream port only while unlocked); bit reads zero
module plsc_port_regs
#(
    parameter int TS_RUN = plsc_pkg::TS_AUTO_RUN
)
(
    input  wire logic         clock,
    input  wire logic         reset_n,
    // configuration port
    input  wire logic [11:0]  cfg_addr,
    input  wire logic [31:0]  cfg_wdata,
    input  wire logic         cfg_wr,
    input  wire logic         cfg_rd,
    output logic      [31:0]  cfg_rdata,
    // static port configuration
    input  wire logic         is_upstream_port,
    input  wire logic         base_rev_1_1,
    input  wire logic         bw_notify_capable,
    input  wire logic         dl_active_capable,
    input  wire logic         slot_implemented,
    // strap pins
    input  wire logic         upstream_common_clock_strap,
    input  wire logic         downstream_common_clock_strap,
    // serial eeprom configuration load
    input  wire logic         eeprom_load,
    input  wire logic         eeprom_slot_clock,
    input  wire logic [5:0]   eeprom_slot_caps,
    // link and physical layer state
    input  wire logic [3:0]   link_speed,
    input  wire logic [5:0]   link_width,
    input  wire logic         training_in_progress,
    input  wire logic         training_failed,
    input  wire logic         data_link_active,
    input  wire logic         data_link_down,
    input  wire logic         retrain_done,
    input  wire logic         auto_change_reliability,
    input  wire logic         auto_change_other,
    input  wire logic         ts_received,
    input  wire logic         ts_auto_change,
    // to the link layer and the interrupt controller
    output logic              retrain_request,
    output logic              irq
);
    import plsc_pkg::*;

    typedef struct packed {
        logic [31:0]                rdata;
        logic                       irq;
        logic                       retrain;
        logic                       retrain_pend;
        logic                       bw_irq_en;
        logic                       abw_irq_en;
        logic                       bw_sts;
        logic                       abw_sts;
        logic                       training_error;
        logic                       dla_prev;
        logic                       slot_clk;
        logic [SCAP_FLAG_COUNT-1:0] slot_caps;
        logic                       unlock;
        logic [EVT_COUNT-1:0]       evt_sts;
        logic [EVT_COUNT-1:0]       evt_mask;
        logic [3:0]                 ts_cnt;
        logic [1:0]                 strap_cnt;
        logic                       us_s1;
        logic                       us_s2;
        logic                       ds_s1;
        logic                       ds_s2;
    } plsc_state_t;

    plsc_state_t s_q;
    plsc_state_t s_d;

    logic        bw_ok;
    logic        wr_lctl;
    logic        wr_lsts;
    logic        wr_scap;
    logic        sw_may_lock;
    logic        bw_set;
    logic        abw_set;
    logic        ts_run_hit;
    logic [15:0] lctl_view;
    logic [15:0] lsts_view;
    logic [31:0] scap_view;
    logic [EVT_COUNT-1:0] evt_set;

    ////////////////////////////////////////////////////////////////////////
    // decode and qualification

    // bandwidth fields exist only with the capability and outside 1.1 mode
    assign bw_ok = bw_notify_capable & ~base_rev_1_1;

    assign wr_lctl = cfg_wr & (cfg_addr == LINK_CONTROL_OFFSET);
    assign wr_lsts = cfg_wr & (cfg_addr == LINK_STATUS_OFFSET);
    assign wr_scap = cfg_wr & (cfg_addr == SLOT_CAPS_OFFSET);

    // lockable fields accept software writes only while unlocked
    assign sw_may_lock = s_q.unlock;

    // full run of flagged ordered sets; only downstream ports act on it
    assign ts_run_hit = ts_received & ts_auto_change
                        & (s_q.ts_cnt == 4'(TS_RUN - 1))
                        & ~is_upstream_port;

    // a retrain completes cleanly only if no link-down was seen meanwhile
    assign bw_set = bw_ok & (
                    (s_q.retrain_pend & retrain_done & ~data_link_down)
                    | (auto_change_reliability & ~data_link_down));
    assign abw_set = bw_ok & (auto_change_other | ts_run_hit);

    assign evt_set[EVT_BW_MGMT]     = bw_set;
    assign evt_set[EVT_AUTO_BW]     = abw_set;
    assign evt_set[EVT_TRAIN_ERROR] = training_failed & ~base_rev_1_1;
    assign evt_set[EVT_DL_CHANGE]   = data_link_active ^ s_q.dla_prev;

    ////////////////////////////////////////////////////////////////////////
    // read views of the three documented registers

    always_comb
    begin
        lctl_view = 16'h0_000;
        // retrain bit always reads zero
        lctl_view[LCTL_BW_IRQ_EN_BIT]  = s_q.bw_irq_en & bw_ok;
        lctl_view[LCTL_ABW_IRQ_EN_BIT] = s_q.abw_irq_en & bw_ok;
    end

    always_comb
    begin
        lsts_view = 16'h0_000;
        lsts_view[LSTS_SPEED_LSB +: 4] = link_speed;
        lsts_view[LSTS_WIDTH_LSB +: 6] = link_width;
        // undefined in 1.1 mode; it reads zero there
        lsts_view[LSTS_TRAINING_ERROR_BIT]       = s_q.training_error & ~base_rev_1_1;
        lsts_view[LSTS_TRAIN_BIT]      = training_in_progress;
        lsts_view[LSTS_SLOT_CLK_BIT]   = s_q.slot_clk;
        lsts_view[LSTS_DL_ACTIVE_BIT]  = data_link_active
                                         & dl_active_capable;
        lsts_view[LSTS_BW_STS_BIT]     = s_q.bw_sts & bw_ok;
        lsts_view[LSTS_ABW_STS_BIT]    = s_q.abw_sts & bw_ok;
    end

    // presence flags vanish when the port has no slot
    always_comb
    begin
        scap_view = 32'h0000_0000;
        scap_view[SCAP_FLAG_COUNT-1:0] = s_q.slot_caps
                  & {SCAP_FLAG_COUNT{slot_implemented}};
    end

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb
    begin
        s_d = s_q;

        // strap synchronisers
        s_d.us_s1 = upstream_common_clock_strap;
        s_d.us_s2 = s_q.us_s1;
        s_d.ds_s1 = downstream_common_clock_strap;
        s_d.ds_s2 = s_q.ds_s1;

        // catch the strap once the synchronisers hold a settled value
        // the counter parks one past the settle point: the capture then
        // happens once and never undoes a later eeprom or software value
        if (s_q.strap_cnt != STRAP_SETTLE + 2'h1)
        begin
            s_d.strap_cnt = s_q.strap_cnt + 2'h1;
        end
        if (s_q.strap_cnt == STRAP_SETTLE)
        begin
            s_d.slot_clk = is_upstream_port ? s_q.us_s2
                                            : s_q.ds_s2;
        end

        // eeprom load overrides straps and ignores the unlock control
        if (eeprom_load)
        begin
            s_d.slot_clk  = eeprom_slot_clock;
            s_d.slot_caps = eeprom_slot_caps;
        end

        // software writes
        s_d.retrain = 1'b0;
        if (wr_lctl)
        begin
            if (bw_ok)
            begin
                s_d.bw_irq_en  = cfg_wdata[LCTL_BW_IRQ_EN_BIT];
                s_d.abw_irq_en = cfg_wdata[LCTL_ABW_IRQ_EN_BIT];
            end
            // upstream retrain is held off unless unlocked
            if (cfg_wdata[LCTL_RETRAIN_BIT]
                && (!is_upstream_port || s_q.unlock))
            begin
                s_d.retrain      = 1'b1;
                s_d.retrain_pend = 1'b1;
            end
        end
        if (wr_lsts)
        begin
            if (sw_may_lock)
            begin
                s_d.slot_clk = cfg_wdata[LSTS_SLOT_CLK_BIT];
            end
            if (cfg_wdata[LSTS_BW_STS_BIT])
            begin
                s_d.bw_sts = 1'b0;
            end
            if (cfg_wdata[LSTS_ABW_STS_BIT])
            begin
                s_d.abw_sts = 1'b0;
            end
        end
        if (wr_scap && sw_may_lock && slot_implemented)
        begin
            // button, power ctrl, sensor, indicators, surprise removal
            s_d.slot_caps = cfg_wdata[SCAP_FLAG_COUNT-1:0];
        end
        if (cfg_wr && cfg_addr == EVENT_STATUS_OFFSET)
        begin
            s_d.evt_sts = s_q.evt_sts & ~cfg_wdata[EVT_COUNT-1:0];
        end
        if (cfg_wr && cfg_addr == EVENT_MASK_OFFSET)
        begin
            s_d.evt_mask = cfg_wdata[EVT_COUNT-1:0];
        end
        if (cfg_wr && cfg_addr == PORT_CONTROL_OFFSET)
        begin
            s_d.unlock = cfg_wdata[PCTL_UNLOCK_BIT];
        end

        // retrain tracking ends on completion or on link down
        if (retrain_done || data_link_down)
        begin
            s_d.retrain_pend = 1'b0;
        end

        // ordered-set run counter; any unflagged set restarts the run
        if (ts_received)
        begin
            if (!ts_auto_change || ts_run_hit
                || s_q.ts_cnt == 4'(TS_RUN - 1))
            begin
                s_d.ts_cnt = 4'h0;
            end
            else
            begin
                s_d.ts_cnt = s_q.ts_cnt + 4'h1;
            end
        end

        // training error holds until the data link comes up again
        if (data_link_active)
        begin
            s_d.training_error = 1'b0;
        end
        if (training_failed && !base_rev_1_1)
        begin
            s_d.training_error = 1'b1;
        end

        // hardware sets win over a same-cycle write-one clear
        if (bw_set)
        begin
            s_d.bw_sts = 1'b1;
        end
        if (abw_set)
        begin
            s_d.abw_sts = 1'b1;
        end
        s_d.evt_sts  = s_d.evt_sts | evt_set;
        s_d.dla_prev = data_link_active;

        // one level output; built from next state so it tracks the flags
        s_d.irq = (s_d.bw_sts & s_d.bw_irq_en & bw_ok)
                  | (s_d.abw_sts & s_d.abw_irq_en & bw_ok)
                  | (|(s_d.evt_sts & s_d.evt_mask));

        // read data stand only in the cycle after the read strobe
        s_d.rdata = 32'h0000_0000;
        if (cfg_rd)
        begin
            unique case (cfg_addr)
                LINK_CONTROL_OFFSET: s_d.rdata = {16'h0_000, lctl_view};
                LINK_STATUS_OFFSET:  s_d.rdata = {16'h0_000, lsts_view};
                SLOT_CAPS_OFFSET:    s_d.rdata = scap_view;
                EVENT_STATUS_OFFSET:
                    s_d.rdata[EVT_COUNT-1:0] = s_q.evt_sts;
                EVENT_MASK_OFFSET:
                    s_d.rdata[EVT_COUNT-1:0] = s_q.evt_mask;
                PORT_CONTROL_OFFSET:
                    s_d.rdata[PCTL_UNLOCK_BIT] = s_q.unlock;
                default:             s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign cfg_rdata       = s_q.rdata;
    assign retrain_request = s_q.retrain;
    assign irq             = s_q.irq;

endmodule

// ---- rtl/plsc_pkg.sv ----
package plsc_pkg;

    // register byte addresses on the 12-bit configuration port
    localparam logic [11:0] LINK_CONTROL_OFFSET  = 12'h0_050;
    localparam logic [11:0] LINK_STATUS_OFFSET   = 12'h0_052;
    localparam logic [11:0] SLOT_CAPS_OFFSET     = 12'h0_054;
    localparam logic [11:0] EVENT_STATUS_OFFSET  = 12'h0_100;
    localparam logic [11:0] EVENT_MASK_OFFSET    = 12'h0_104;
    localparam logic [11:0] PORT_CONTROL_OFFSET  = 12'h0_108;

    // link control fields
    localparam int LCTL_RETRAIN_BIT    = 5;
    localparam int LCTL_BW_IRQ_EN_BIT  = 10;
    localparam int LCTL_ABW_IRQ_EN_BIT = 11;

    // link status fields
    localparam int LSTS_SPEED_LSB      = 0;
    localparam int LSTS_WIDTH_LSB      = 4;
    localparam int LSTS_TRAINING_ERROR_BIT       = 10;
    localparam int LSTS_TRAIN_BIT      = 11;
    localparam int LSTS_SLOT_CLK_BIT   = 12;
    localparam int LSTS_DL_ACTIVE_BIT  = 13;
    localparam int LSTS_BW_STS_BIT     = 14;
    localparam int LSTS_ABW_STS_BIT    = 15;

    // slot capability fields: bits 0..5 are the presence/surprise flags
    localparam int SCAP_FLAG_COUNT     = 6;

    // port control field
    localparam int PCTL_UNLOCK_BIT     = 0;

    // event status / mask bit positions
    localparam int EVT_BW_MGMT         = 0;
    localparam int EVT_AUTO_BW         = 1;
    localparam int EVT_TRAIN_ERROR     = 2;
    localparam int EVT_DL_CHANGE       = 3;
    localparam int EVT_COUNT           = 4;

    // reset values
    localparam logic [3:0] LINK_SPEED_RESET = 4'h1;
    localparam logic [5:0] LINK_WIDTH_RESET = 6'h00;

    // consecutive ordered sets with the autonomous-change flag
    localparam int TS_AUTO_RUN         = 8;

    // cycles the strap synchronisers need before the strap is caught
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

endpackage

// ---- bench/plsc_port_regs_props.sv ----
`timescale 1ns/1ps
module plsc_port_regs_props
    import plsc_pkg::*;
#(
    parameter int TS_RUN = 8
)
(
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic [11:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [31:0] cfg_rdata,
    input wire logic        is_upstream_port,
    input wire logic        base_rev_1_1,
    input wire logic        bw_notify_capable,
    input wire logic        slot_implemented,
    input wire logic [3:0]  link_speed,
    input wire logic        training_in_progress,
    input wire logic        retrain_request
);
    // decoded strobes; bandwidth fields are dead in either of two modes
    wire logic rd_c  = cfg_rd && cfg_addr == LINK_CONTROL_OFFSET;
    wire logic rd_s  = cfg_rd && cfg_addr == LINK_STATUS_OFFSET;
    wire logic wr_rt = cfg_wr && cfg_addr == LINK_CONTROL_OFFSET
                       && cfg_wdata[LCTL_RETRAIN_BIT];
    wire logic bw_off = base_rev_1_1 || !bw_notify_capable;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    AST_SPEED_SHOWN: assert property (
        rd_s |=> cfg_rdata[3:0] == $past(link_speed))
        else $error("speed field differs from link speed");
    AST_TRAIN_SHOWN: assert property (
        rd_s |=> cfg_rdata[11] == $past(training_in_progress))
        else $error("training bit differs from link state");
    AST_RETRAIN_READ: assert property (
        rd_c |=> !cfg_rdata[5])
        else $error("retrain bit read back as one");
    AST_RETRAIN_PULSE: assert property (
        wr_rt && !is_upstream_port |=> retrain_request ##1 !retrain_request)
        else $error("retrain request not a single pulse");
    AST_RETRAIN_CAUSE: assert property (
        !wr_rt |=> !retrain_request)
        else $error("retrain request without a write");
    AST_BW_STS_ZERO: assert property (
        rd_s && bw_off |=> cfg_rdata[15:14] == 2'h0)
        else $error("bandwidth status bits not zero");
    AST_BW_EN_ZERO: assert property (
        rd_c && bw_off |=> cfg_rdata[11:10] == 2'h0)
        else $error("bandwidth enables not zero");
    AST_SLOT_ZERO: assert property (
        cfg_rd && cfg_addr == SLOT_CAPS_OFFSET && !slot_implemented
        |=> cfg_rdata[5:0] == 6'h00)
        else $error("slot flags not zero without a slot");
endmodule

bind plsc_port_regs plsc_port_regs_props #(.TS_RUN(TS_RUN)) props_inst (
    .clock(clock), .reset_n(reset_n), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_rdata(cfg_rdata), .is_upstream_port(is_upstream_port),
    .base_rev_1_1(base_rev_1_1), .bw_notify_capable(bw_notify_capable),
    .slot_implemented(slot_implemented), .link_speed(link_speed),
    .training_in_progress(training_in_progress),
    .retrain_request(retrain_request));

// ---- bench/plsc_link_partner.sv ----
`timescale 1ns/1ps
module plsc_link_partner
(
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       retrain_request,
    input  wire logic       drop_link,
    input  wire logic [3:0] delay,
    output logic            training_in_progress,
    output logic            retrain_done,
    output logic            data_link_down,
    output logic            ts_received,
    output logic            ts_auto_change
);
    logic [4:0] cnt_q;
    initial
    begin
        ts_received = 1'b0;
        ts_auto_change = 1'b0;
    end
    // training lasts delay+4 cycles so slow and quick partners both occur
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q <= 5'h00;
            training_in_progress <= 1'b0;
            retrain_done <= 1'b0;
            data_link_down <= 1'b0;
        end
        else
        begin
            retrain_done <= cnt_q == 5'h01;
            data_link_down <= retrain_request && drop_link;
            training_in_progress <= retrain_request || cnt_q > 5'h01;
            if (retrain_request)
                cnt_q <= {1'b0, delay} + 5'h04;
            else if (cnt_q != 5'h00)
                cnt_q <= cnt_q - 5'h01;
        end
    end
    // ordered sets; the flag flips when no set is valid
    task automatic send_ts(input int n, input logic flag);
        repeat (n)
        begin
            @(posedge clock);
            ts_received <= 1'b1;
            ts_auto_change <= flag;
            @(posedge clock);
            ts_received <= 1'b0;
            ts_auto_change <= ~flag;
        end
    endtask
endmodule

// ---- bench/port_link_status_slot_caps_tb.sv ----
`timescale 1ns/1ps
module port_link_status_slot_caps_tb;
    import plsc_pkg::*;
    logic clock, reset_n, cfg_wr, cfg_rd, base_rev_1_1, bw_notify_capable;
    logic slot_implemented, up_strap, dn_strap, eeprom_load, eeprom_clk;
    logic is_up, dla_cap;
    logic training_failed, data_link_active, auto_rel, auto_oth, drop_link;
    logic training, retrain_done, dl_down, ts_rx, ts_flag, retrain_req, irq;
    logic [11:0] cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [5:0]  eeprom_caps, link_width;
    logic [3:0]  link_speed, delay;
    int          n_mismatch, total_checks, i;
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, e);
        @(posedge clock);
        cfg_addr <= a;
        cfg_rd <= 1'b1;
        @(posedge clock);
        cfg_rd <= 1'b0;
        #1 chk((cfg_rdata & m) === e, "read data");
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge clock);
        cfg_wr <= 1'b0;
    endtask
    // one-cycle event pulse, returns just after the sampling edge
    task automatic pulse(input int k);
        @(posedge clock);
        case (k)
            0: auto_oth <= 1'b1;
            1: auto_rel <= 1'b1;
            2: training_failed <= 1'b1;
            default: eeprom_load <= 1'b1;
        endcase
        @(posedge clock);
        {auto_oth, auto_rel, training_failed, eeprom_load} <= 4'h0;
        #1;
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    plsc_port_regs plsc_port_regs_inst (.clock(clock), .reset_n(reset_n),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .is_upstream_port(is_up),
        .base_rev_1_1(base_rev_1_1), .bw_notify_capable(bw_notify_capable),
        .dl_active_capable(dla_cap), .slot_implemented(slot_implemented),
        .upstream_common_clock_strap(up_strap),
        .downstream_common_clock_strap(dn_strap), .eeprom_load(eeprom_load),
        .eeprom_slot_clock(eeprom_clk), .eeprom_slot_caps(eeprom_caps),
        .link_speed(link_speed), .link_width(link_width),
        .training_in_progress(training), .training_failed(training_failed),
        .data_link_active(data_link_active), .data_link_down(dl_down),
        .retrain_done(retrain_done), .auto_change_reliability(auto_rel),
        .auto_change_other(auto_oth), .ts_received(ts_rx),
        .ts_auto_change(ts_flag), .retrain_request(retrain_req), .irq(irq));
    plsc_link_partner plsc_link_partner_inst (.clock(clock),
        .reset_n(reset_n), .retrain_request(retrain_req),
        .drop_link(drop_link), .delay(delay),
        .training_in_progress(training), .retrain_done(retrain_done),
        .data_link_down(dl_down), .ts_received(ts_rx),
        .ts_auto_change(ts_flag));
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {cfg_wr, cfg_rd, base_rev_1_1, slot_implemented, eeprom_load} = 0;
        is_up = 1'b0;
        dla_cap = 1'b1;
        {training_failed, data_link_active, auto_rel, auto_oth} = 0;
        {drop_link, cfg_addr, cfg_wdata, eeprom_clk, eeprom_caps} = 0;
        {reset_n, n_mismatch, total_checks, bw_notify_capable} = 1;
        void'($urandom(32'h7a1b_10bb));
        link_speed = 4'($urandom_range(2, 1));
        link_width = 6'($urandom);
        // straps differ so that the port's own strap is the one seen
        dn_strap = 1'($urandom);
        up_strap = ~dn_strap;
        delay = 4'($urandom);
        reset_n = 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(LINK_STATUS_OFFSET, 32'hffff_ffff,
           {19'h0_0000, dn_strap, 2'h0, link_width, link_speed});
        wr(LINK_CONTROL_OFFSET, 32'h0000_0c00);
        rd(LINK_CONTROL_OFFSET, 32'h0000_0c20, 32'h0000_0c00);
        // autonomous changes: other reasons, then reliability
        for (i = 0; i < 2; i++)
        begin
            pulse(i);
            chk(irq, "no interrupt on bandwidth event");
            rd(LINK_STATUS_OFFSET, 32'h0000_c000,
               i ? 32'h0000_4000 : 32'h0000_8000);
            wr(LINK_STATUS_OFFSET, 32'h0000_c000);
            @(posedge clock);
            #1 chk(!irq, "interrupt stays after clear");
        end
        // software retrain, once clean and once through link down
        for (i = 0; i < 2; i++)
        begin
            drop_link <= i[0];
            delay <= 4'($urandom_range(12, 2));
            wr(LINK_CONTROL_OFFSET, 32'h0000_0c20);
            #1 chk(retrain_req, "no retrain request");
            rd(LINK_STATUS_OFFSET, 32'h0000_0800, 32'h0000_0800);
            for (int j = 0; j < 100 && !retrain_done; j++)
            begin
                @(posedge clock);
                #1;
            end
            chk(retrain_done, "retrain never finished");
            if (!retrain_done)
                final_report();
            rd(LINK_STATUS_OFFSET, 32'h0000_4800,
               i ? 32'h0000_0000 : 32'h0000_4000);
            wr(LINK_STATUS_OFFSET, 32'h0000_c000);
        end
        // flagged ordered-set run broken by an unflagged set
        plsc_link_partner_inst.send_ts(7, 1'b1);
        plsc_link_partner_inst.send_ts(1, 1'b0);
        plsc_link_partner_inst.send_ts(7, 1'b1);
        rd(LINK_STATUS_OFFSET, 32'h0000_8000, 32'h0000_0000);
        plsc_link_partner_inst.send_ts(1, 1'b1);
        rd(LINK_STATUS_OFFSET, 32'h0000_8000, 32'h0000_8000);
        wr(LINK_STATUS_OFFSET, 32'h0000_c000);
        // training error through the masked event interrupt
        wr(EVENT_STATUS_OFFSET, 32'h0000_000f);
        wr(EVENT_MASK_OFFSET, 32'h0000_0004);
        pulse(2);
        chk(irq, "no event interrupt");
        rd(LINK_STATUS_OFFSET, 32'h0000_0400, 32'h0000_0400);
        wr(EVENT_STATUS_OFFSET, 32'h0000_0004);
        @(posedge clock);
        data_link_active <= 1'b1;
        #1 chk(!irq, "event interrupt stays");
        rd(LINK_STATUS_OFFSET, 32'h0000_2400, 32'h0000_2000);
        rd(12'h0_0f0, 32'hffff_ffff, 32'h0000_0000);
        // slot flags loaded by eeprom, locked against software
        @(posedge clock);
        slot_implemented <= 1'b1;
        eeprom_caps <= 6'($urandom);
        eeprom_clk <= ~dn_strap;
        pulse(3);
        rd(SLOT_CAPS_OFFSET, 32'h0000_003f, {26'h0, eeprom_caps});
        rd(LINK_STATUS_OFFSET, 32'h0000_1000,
           {19'h0, ~dn_strap, 12'h0});
        wr(SLOT_CAPS_OFFSET, {26'h0, ~eeprom_caps});
        rd(SLOT_CAPS_OFFSET, 32'h0000_003f, {26'h0, eeprom_caps});
        // once unlocked, software may rewrite the flags
        wr(PORT_CONTROL_OFFSET, 32'h0000_0001);
        wr(SLOT_CAPS_OFFSET, {26'h0, ~eeprom_caps});
        rd(SLOT_CAPS_OFFSET, 32'h0000_003f, {26'h0, ~eeprom_caps});
        @(posedge clock);
        slot_implemented <= 1'b0;
        rd(SLOT_CAPS_OFFSET, 32'h0000_003f, 32'h0000_0000);
        // bandwidth fields without capability, then in base 1.1 mode
        for (i = 0; i < 2; i++)
        begin
            @(posedge clock);
            bw_notify_capable <= i[0];
            base_rev_1_1 <= i[0];
            wr(LINK_CONTROL_OFFSET, 32'h0000_0c00);
            rd(LINK_CONTROL_OFFSET, 32'h0000_0c00, 32'h0000_0000);
            pulse(0);
            chk(!irq, "interrupt while disabled");
            rd(LINK_STATUS_OFFSET, 32'h0000_c000, 32'h0000_0000);
        end
        // second reset as the upstream port without link-active capability
        @(posedge clock);
        is_up <= 1'b1;
        dla_cap <= 1'b0;
        base_rev_1_1 <= 1'b0;
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(LINK_STATUS_OFFSET, 32'h0000_3000,
           {19'h0, up_strap, 12'h0});
        plsc_link_partner_inst.send_ts(8, 1'b1);
        rd(LINK_STATUS_OFFSET, 32'h0000_8000, 32'h0000_0000);
        // upstream retrain is held off until the unlock control is set
        wr(LINK_CONTROL_OFFSET, 32'h0000_0020);
        #1 chk(!retrain_req, "upstream retrain while locked");
        wr(PORT_CONTROL_OFFSET, 32'h0000_0001);
        wr(LINK_CONTROL_OFFSET, 32'h0000_0020);
        #1 chk(retrain_req, "no upstream retrain unlocked");
        final_report();
    end
endmodule
